// ---- dscp_defs.svh ----
// Constants for the serial configuration port: word layout, offsets, timing.
// Included by the package and by both ends; holds definitions only.
`ifndef DSCP_DEFS_SVH
`define DSCP_DEFS_SVH

`define DSCP_WORD_W       18
`define DSCP_FORCE_TYPE   17
`define DSCP_GAIN_HI      16
`define DSCP_GAIN_LO      14
`define DSCP_RANGE_HI     13
`define DSCP_RANGE_LO     11
`define DSCP_CLAMP        10
`define DSCP_SPARE        9
`define DSCP_FORCE_FLOAT  8
`define DSCP_MEAS_FLOAT   7
`define DSCP_CMP_FLOAT    6
`define DSCP_LEAD_HI      5
`define DSCP_LEAD_LO      4
`define DSCP_BYP_HI       3
`define DSCP_BYP_LO       2
`define DSCP_INPUT_LOAD   1
`define DSCP_OUTPUT_LOAD  0
`define DSCP_WORD_RESET   18'h0_0000

`define DSCP_REG_TX       8'h00
`define DSCP_REG_CMD      8'h04
`define DSCP_REG_STATUS   8'h08
`define DSCP_REG_RX       8'h0C
`define DSCP_CMD_FRAME    0
`define DSCP_CMD_QUICK    1
`define DSCP_CMD_STROBE   2

`define DSCP_PCLK_NS      10
`define DSCP_SCLK_HALF_NS 80
`define DSCP_CS_LOW_NS    100
`define DSCP_SCLK_HALF_CYC ((`DSCP_SCLK_HALF_NS + `DSCP_PCLK_NS - 1) / `DSCP_PCLK_NS)
`define DSCP_CS_LOW_CYC    ((`DSCP_CS_LOW_NS + `DSCP_PCLK_NS - 1) / `DSCP_PCLK_NS)

`endif

// ---- dscp_pkg.sv ----
// Types shared by both ends of the serial configuration port.
// Assumes dscp_defs.svh is on the include path.
`include "dscp_defs.svh"

package dscp_pkg;

    typedef enum logic [2:0] {
        rng_200ua,
        rng_2ma,
        rng_20ma,
        rng_800ma,
        rng_external
    } dscp_range_type;

    typedef enum logic [2:0] {
        hs_idle,
        hs_low,
        hs_high,
        hs_tail,
        hs_gap,
        hs_quick,
        hs_strobe
    } dscp_host_state_type;

endpackage

// ---- dscp_link_if.sv ----
// Three-wire link plus update strobe and daisy-chain output.
// The bench joins both ends through one instance of this interface.
`timescale 1ns/1ps
`default_nettype none

interface dscp_link_if;
    logic sclk;
    logic sdi;
    logic cs_n;
    logic load_n;
    logic sdo;

    modport dev (
        input  sclk,
        input  sdi,
        input  cs_n,
        input  load_n,
        output sdo
    );

    modport host (
        output sclk,
        output sdi,
        output cs_n,
        output load_n,
        input  sdo
    );
endinterface

`default_nettype wire

// ---- dscp_sync.sv ----
// Two-flop synchroniser for a group of independent levels.
// Each bit crosses on its own; no bus coherence is implied.
`timescale 1ns/1ps
`default_nettype none

module dscp_sync #(
    parameter int           W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    // System
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Levels
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    if (W < 1) $error("dscp_sync: W must be at least 1");

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= RST;
            sync_out <= RST;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

`default_nettype wire

// ---- dscp_device.sv ----
// Device end of the serial configuration port: shift, holding and active
// word, flow control at chip-select release, update strobe, range decode.
// Assumes the link pins are asynchronous to pclk and slow against it.
`timescale 1ns/1ps
`default_nettype none
`include "dscp_defs.svh"

module dscp_device (
    // System
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Serial link
    dscp_link_if.dev                       link,
    // Direct pin
    input  wire logic                      measure_float_pin_n,
    // Staged words
    output logic [`DSCP_WORD_W-1:0]        holding_word,
    output logic [`DSCP_WORD_W-1:0]        active_word,
    // Decoded configuration
    output logic                           force_type_bit,
    output logic [2:0]                     gain_sel,
    output logic                           clamp_enable_bit,
    output logic                           force_float_bit,
    output logic                           measure_float,
    output logic                           comparator_float_bit,
    output logic [1:0]                     lead_comp,
    output logic [1:0]                     bypass_comp,
    output dscp_pkg::dscp_range_type       current_range,
    output logic                           external_amp_select,
    output logic                           spare_violation
);
    import dscp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection

    logic                    sclk_s;
    logic                    sdi_s;
    logic                    cs_n_s;
    logic                    load_n_s;
    logic                    meas_pin_n_s;
    logic                    sclk_p_q;
    logic                    cs_n_p_q;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    cs_rise;
    logic                    cs_fall;

    // Low-true pins reset high, so release makes no false edge
    dscp_sync #(
        .W   (5),
        .RST (5'h07)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({link.sclk, link.sdi, link.cs_n, link.load_n, measure_float_pin_n}),
        .sync_out ({sclk_s, sdi_s, cs_n_s, load_n_s, meas_pin_n_s})
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_p_q <= 1'b0;
            cs_n_p_q <= 1'b1;
        end else begin
            sclk_p_q <= sclk_s;
            cs_n_p_q <= cs_n_s;
        end
    end

    // Data and clock share the same synchroniser delay, so sdi_s is aligned
    assign sclk_rise = sclk_s & ~sclk_p_q;
    assign sclk_fall = ~sclk_s & sclk_p_q;
    assign cs_rise   = cs_n_s & ~cs_n_p_q;
    assign cs_fall   = ~cs_n_s & cs_n_p_q;

    ////////////////////////////////////////////////////////////////////////
    // Shift register and daisy-chain output

    logic [`DSCP_WORD_W-1:0] shift_q;
    logic                    sdo_q;
    logic                    edge_seen_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_q <= `DSCP_WORD_RESET;
        end else if (!cs_n_s && sclk_rise) begin
            // Older bits fall off the top; the last word received wins
            shift_q <= {shift_q[`DSCP_WORD_W-2:0], sdi_s};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_q <= 1'b0;
        end else if (!cs_n_s && sclk_fall) begin
            sdo_q <= shift_q[`DSCP_WORD_W-1];
        end
    end

    assign link.sdo = sdo_q;

    // Any clock edge inside the frame makes it a real transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_seen_q <= 1'b0;
        end else if (cs_fall) begin
            edge_seen_q <= 1'b0;
        end else if (!cs_n_s && (sclk_rise || sclk_fall)) begin
            edge_seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holding and active words

    logic [`DSCP_WORD_W-1:0] holding_q;
    logic [`DSCP_WORD_W-1:0] active_q;
    logic [`DSCP_WORD_W-1:0] active_d;
    logic                    hold_load;
    logic                    out_load;

    assign hold_load = shift_q[`DSCP_INPUT_LOAD];
    assign out_load  = shift_q[`DSCP_OUTPUT_LOAD];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holding_q <= `DSCP_WORD_RESET;
        end else if (cs_rise && edge_seen_q && hold_load) begin
            holding_q <= shift_q;
        end
    end

    always_comb begin
        active_d = active_q;
        if (cs_rise) begin
            if (!edge_seen_q) begin
                active_d = holding_q;
            end else begin
                case ({hold_load, out_load})
                    2'b01: begin
                        active_d = holding_q;
                    end
                    2'b10: begin
                        // Strobe already low: new word goes straight through
                        if (!load_n_s) begin
                            active_d = shift_q;
                        end
                    end
                    2'b11: begin
                        active_d = shift_q;
                    end
                    default: begin
                        active_d = active_q;
                    end
                endcase
            end
        end else if (!load_n_s) begin
            // Level-sensitive: a pulse copies once, a held strobe tracks
            active_d = holding_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= `DSCP_WORD_RESET;
        end else begin
            active_q <= active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded outputs from the active word; measure float also takes the pin, the spare flag the holding word

    dscp_range_type          range_q;
    logic                    ext_q;
    logic                    meas_float_q;
    logic                    spare_q;
    logic [2:0]              range_field;

    assign range_field = active_q[`DSCP_RANGE_HI:`DSCP_RANGE_LO];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            range_q <= rng_200ua;
            ext_q   <= 1'b0;
        end else begin
            ext_q <= range_field[2];
            if (range_field[2]) begin
                range_q <= rng_external;
            end else begin
                case (range_field[1:0])
                    2'b00:   range_q <= rng_200ua;
                    2'b01:   range_q <= rng_2ma;
                    2'b10:   range_q <= rng_20ma;
                    default: range_q <= rng_800ma;
                endcase
            end
        end
    end

    // Measure float is shared: either the pin or the word bit, both low-true
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_float_q <= 1'b1;
        end else begin
            meas_float_q <= !meas_pin_n_s || !active_q[`DSCP_MEAS_FLOAT];
        end
    end

    // Diagnostic only: flags a held word with the spare bit set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spare_q <= 1'b0;
        end else begin
            spare_q <= holding_q[`DSCP_SPARE];
        end
    end

    assign holding_word         = holding_q;
    assign active_word          = active_q;
    assign force_type_bit       = active_q[`DSCP_FORCE_TYPE];
    assign gain_sel             = active_q[`DSCP_GAIN_HI:`DSCP_GAIN_LO];
    assign clamp_enable_bit     = active_q[`DSCP_CLAMP];
    assign force_float_bit      = active_q[`DSCP_FORCE_FLOAT];
    assign comparator_float_bit = active_q[`DSCP_CMP_FLOAT];
    assign lead_comp            = active_q[`DSCP_LEAD_HI:`DSCP_LEAD_LO];
    assign bypass_comp          = active_q[`DSCP_BYP_HI:`DSCP_BYP_LO];
    assign measure_float        = meas_float_q;
    assign current_range        = range_q;
    assign external_amp_select  = ext_q;
    assign spare_violation      = spare_q;
endmodule

`default_nettype wire

// ---- dscp_host.sv ----
// Host end: APB slave registers that launch frames, quick loads and
// update strobes on the link, and capture the word shifted back.
// Assumes the device end synchronises the link to its own clock.
`timescale 1ns/1ps
`default_nettype none
`include "dscp_defs.svh"

module dscp_host #(
    parameter int SCLK_HALF_CYC = `DSCP_SCLK_HALF_CYC,
    parameter int CS_LOW_CYC    = `DSCP_CS_LOW_CYC
) (
    // System
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    dscp_link_if.host        link
);
    import dscp_pkg::*;

    // Device needs several pclk cycles per half period to see each edge
    if (SCLK_HALF_CYC < 4 || SCLK_HALF_CYC > 255) $error("dscp_host: bad SCLK_HALF_CYC");
    if (CS_LOW_CYC < 4 || CS_LOW_CYC > 255) $error("dscp_host: bad CS_LOW_CYC");

    localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF_CYC - 1);
    localparam logic [7:0] CSLO_M1 = 8'(CS_LOW_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // APB registers

    logic [`DSCP_WORD_W-1:0] tx_q;
    logic [`DSCP_WORD_W-1:0] rx_q;
    logic [31:0]             prdata_q;
    logic [31:0]             rd_d;
    logic                    mapped;
    logic                    wr_en;
    logic                    busy;
    logic                    go_frame;
    logic                    go_quick;
    logic                    go_strobe;
    dscp_host_state_type     state_q;

    assign mapped = (paddr == `DSCP_REG_TX) || (paddr == `DSCP_REG_CMD)
                 || (paddr == `DSCP_REG_STATUS) || (paddr == `DSCP_REG_RX);
    assign wr_en     = psel && penable && pwrite && mapped;
    assign busy      = (state_q != hs_idle);
    assign go_frame  = wr_en && (paddr == `DSCP_REG_CMD) && pwdata[`DSCP_CMD_FRAME];
    assign go_quick  = wr_en && (paddr == `DSCP_REG_CMD) && pwdata[`DSCP_CMD_QUICK];
    assign go_strobe = wr_en && (paddr == `DSCP_REG_CMD) && pwdata[`DSCP_CMD_STROBE];
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_q <= `DSCP_WORD_RESET;
        end else if (wr_en && (paddr == `DSCP_REG_TX) && !busy) begin
            // Spare bit is forced low whatever software writes
            tx_q <= pwdata[`DSCP_WORD_W-1:0] & ~(18'h0_0001 << `DSCP_SPARE);
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        case (paddr)
            `DSCP_REG_TX:     rd_d[`DSCP_WORD_W-1:0] = tx_q;
            `DSCP_REG_STATUS: rd_d[0] = busy;
            `DSCP_REG_RX:     rd_d[`DSCP_WORD_W-1:0] = rx_q;
            default:          rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_q <= rd_d;
        end
    end

    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer

    logic [`DSCP_WORD_W-1:0] sh_q;
    logic [7:0]              timer_q;
    logic [4:0]              bit_q;
    logic                    sclk_q;
    logic                    sdi_q;
    logic                    cs_n_q;
    logic                    load_n_q;
    logic                    sdo_s;

    dscp_sync #(
        .W (1)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (link.sdo),
        .sync_out (sdo_s)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= hs_idle;
            timer_q  <= 8'h00;
            bit_q    <= 5'h00;
            sh_q     <= `DSCP_WORD_RESET;
            rx_q     <= `DSCP_WORD_RESET;
            sclk_q   <= 1'b0;
            sdi_q    <= 1'b0;
            cs_n_q   <= 1'b1;
            load_n_q <= 1'b1;
        end else if (state_q == hs_idle) begin
            timer_q <= HALF_M1;
            if (go_frame) begin
                cs_n_q  <= 1'b0;
                sdi_q   <= tx_q[`DSCP_WORD_W-1];
                sh_q    <= tx_q;
                bit_q   <= 5'h00;
                state_q <= hs_low;
            end else if (go_quick) begin
                cs_n_q  <= 1'b0;
                timer_q <= CSLO_M1;
                state_q <= hs_quick;
            end else if (go_strobe) begin
                // Only ever after chip select is high again
                load_n_q <= 1'b0;
                timer_q  <= CSLO_M1;
                state_q  <= hs_strobe;
            end
        end else if (timer_q != 8'h00) begin
            timer_q <= timer_q - 8'h01;
        end else begin
            timer_q <= HALF_M1;
            case (state_q)
                hs_low: begin
                    sclk_q  <= 1'b1;
                    state_q <= hs_high;
                end
                hs_high: begin
                    // Late in the high phase, well after the device moved sdo
                    sclk_q <= 1'b0;
                    rx_q   <= {rx_q[`DSCP_WORD_W-2:0], sdo_s};
                    sh_q   <= {sh_q[`DSCP_WORD_W-2:0], 1'b0};
                    bit_q  <= bit_q + 5'h01;
                    if (bit_q == 5'(`DSCP_WORD_W - 1)) begin
                        state_q <= hs_tail;
                    end else begin
                        sdi_q   <= sh_q[`DSCP_WORD_W-2];
                        state_q <= hs_low;
                    end
                end
                hs_tail: begin
                    cs_n_q  <= 1'b1;
                    state_q <= hs_gap;
                end
                hs_quick: begin
                    cs_n_q  <= 1'b1;
                    state_q <= hs_gap;
                end
                hs_strobe: begin
                    load_n_q <= 1'b1;
                    state_q  <= hs_gap;
                end
                default: begin
                    state_q <= hs_idle;
                end
            endcase
        end
    end

    assign link.sclk   = sclk_q;
    assign link.sdi    = sdi_q;
    assign link.cs_n   = cs_n_q;
    assign link.load_n = load_n_q;
endmodule

`default_nettype wire

// ---- dscp_link_properties.sv ----
// Protocol checker for the three-wire link between host and device ends.
// Link signals as plain inputs; assumes default host timing.
`timescale 1ns/1ps
`default_nettype none

module dscp_link_properties (
    // System
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic sclk,
    input wire logic sdi,
    input wire logic cs_n,
    input wire logic load_n,
    input wire logic sdo
);
    logic       sclk_q;
    logic [4:0] rise_cnt_q;

    ////////////////////////////////////////////////////////////////////////////
    // Rises per chip-select window; cleared while deselected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q     <= 1'b0;
            rise_cnt_q <= 5'h00;
        end else begin
            sclk_q <= sclk;
            if (cs_n) begin
                rise_cnt_q <= 5'h00;
            end else if (sclk && !sclk_q) begin
                rise_cnt_q <= rise_cnt_q + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // A window holds a full word or, for a quick load, no clock at all
    property p_frame_bits;
        $rose(cs_n) |-> (rise_cnt_q == 5'h12 || rise_cnt_q == 5'h00);
    endproperty
    a_frame_bits: assert property (p_frame_bits)
        else $error("partial word in window");
    property p_clk_in_frame;
        $rose(sclk) |-> !cs_n;
    endproperty
    a_clk_in_frame: assert property (p_clk_in_frame)
        else $error("clock rose outside frame");
    property p_cs_rise_clk_low;
        $rose(cs_n) |-> !sclk && !$past(sclk);
    endproperty
    a_cs_rise_clk_low: assert property (p_cs_rise_clk_low)
        else $error("select rose with clock high");
    property p_sdi_stable_high;
        sclk && $past(sclk) |-> $stable(sdi);
    endproperty
    a_sdi_stable_high: assert property (p_sdi_stable_high)
        else $error("data moved with clock high");
    property p_sdo_on_fall;
        $changed(sdo) |-> !sclk;
    endproperty
    a_sdo_on_fall: assert property (p_sdo_on_fall)
        else $error("chain output moved while clock high");
    property p_half_period;
        $rose(sclk) |-> sclk [*8] ##1 !sclk;
    endproperty
    a_half_period: assert property (p_half_period)
        else $error("clock high phase not 8 cycles");
    property p_quick_width;
        $fell(cs_n) |-> !cs_n [*8];
    endproperty
    a_quick_width: assert property (p_quick_width)
        else $error("select pulse too short");
    property p_frame_bounded;
        $fell(cs_n) |-> ##[1:400] $rose(cs_n);
    endproperty
    a_frame_bounded: assert property (p_frame_bounded)
        else $error("select low too long");
    // Strobe only with select released; ends promptly
    property p_strobe_pulse;
        $fell(load_n) |-> cs_n throughout (##[1:20] $rose(load_n));
    endproperty
    a_strobe_pulse: assert property (p_strobe_pulse)
        else $error("strobe overlapped frame or stuck");

    c_full_frame: cover property ($rose(cs_n) && rise_cnt_q == 5'h12);
    c_quick_load: cover property ($rose(cs_n) && rise_cnt_q == 5'h00);
    c_strobe: cover property ($rose(load_n));
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Bench: APB drives the host end; device outputs are checked
// against a model of the staging words.
`timescale 1ns/1ps
`default_nettype none
`include "dscp_defs.svh"

module tb_top;
    import dscp_pkg::*;

    logic           pclk;
    logic           presetn;
    logic           psel;
    logic           penable;
    logic           pwrite;
    logic [7:0]     paddr;
    logic [31:0]    pwdata;
    logic [31:0]    prdata;
    logic           pready;
    logic           pslverr;
    logic           pin_n;
    logic           rd_chk;
    logic           dev_chk;
    logic [17:0]    holding_word;
    logic [17:0]    active_word;
    logic           force_type_bit;
    logic [2:0]     gain_sel;
    logic           clamp_enable_bit;
    logic           force_float_bit;
    logic           measure_float;
    logic           comparator_float_bit;
    logic [1:0]     lead_comp;
    logic [1:0]     bypass_comp;
    dscp_range_type current_range;
    logic           external_amp_select;
    logic           spare_violation;
    logic [17:0]    sh_m;
    logic [17:0]    hold_m;
    logic [17:0]    act_m;
    logic [31:0]    seed;
    int             num_errors;
    int             n_checks;
    logic [32:0]    rd_q[$];
    logic [52:0]    dev_q[$];

    dscp_link_if u_dscp_link_if ();
    dscp_host u_dscp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(u_dscp_link_if));
    dscp_device u_dscp_device (.pclk(pclk), .presetn(presetn), .link(u_dscp_link_if),
        .measure_float_pin_n(pin_n), .holding_word(holding_word), .active_word(active_word),
        .force_type_bit(force_type_bit), .gain_sel(gain_sel), .clamp_enable_bit(clamp_enable_bit),
        .force_float_bit(force_float_bit), .measure_float(measure_float),
        .comparator_float_bit(comparator_float_bit), .lead_comp(lead_comp),
        .bypass_comp(bypass_comp), .current_range(current_range),
        .external_amp_select(external_amp_select), .spare_violation(spare_violation));
    dscp_link_properties u_dscp_link_properties (.pclk(pclk), .presetn(presetn),
        .sclk(u_dscp_link_if.sclk), .sdi(u_dscp_link_if.sdi), .cs_n(u_dscp_link_if.cs_n),
        .load_n(u_dscp_link_if.load_n), .sdo(u_dscp_link_if.sdo));

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : 32'h0);
    endfunction

    // Expected device outputs, from the model's words
    function automatic logic [52:0] dev_exp();
        logic [2:0] r;
        r = act_m[13] ? rng_external : dscp_range_type'(act_m[12:11]);
        return {hold_m, act_m, r, act_m[13], ~pin_n | ~act_m[7], hold_m[9], act_m[17],
                act_m[16:14], act_m[10], act_m[8], act_m[6], act_m[5:2]};
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic compare(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Monitor: oldest note against each result
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && rd_chk) begin
            compare({31'h0, pslverr, prdata}, {31'h0, rd_q.pop_front()});
        end
        if (dev_chk) begin
            compare({11'h0, holding_word, active_word, current_range,
                     external_amp_select, measure_float, spare_violation, force_type_bit,
                     gain_sel, clamp_enable_bit, force_float_bit, comparator_float_bit,
                     lead_comp, bypass_comp}, {11'h0, dev_q.pop_front()});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic [32:0] e, output logic [31:0] rd);
        int n;
        @(posedge pclk);
        if (chk) rd_q.push_back(e);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        rd_chk  <= chk;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        rd_chk  <= 1'b0;
        if (n >= 50) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic note_dev();
        dev_q.push_back(dev_exp());
        dev_chk <= 1'b1;
        @(posedge pclk);
        dev_chk <= 1'b0;
    endtask

    // Bounded poll of the busy flag
    task automatic wait_idle();
        logic [31:0] rd;
        int          n;
        for (n = 0; n < 300; n++) begin
            apb(1'b0, `DSCP_REG_STATUS, 32'h0, 1'b0, 33'h0, rd);
            if (rd[0] === 1'b0) break;
        end
        if (n == 300) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic send(input logic [17:0] w);
        logic [17:0] prev;
        logic [31:0] rd;
        prev = sh_m;
        apb(1'b1, `DSCP_REG_TX, {14'h0, w}, 1'b0, 33'h0, rd);
        apb(1'b1, `DSCP_REG_CMD, 32'h1, 1'b0, 33'h0, rd);
        w[9] = 1'b0;
        wait_idle();
        sh_m = w;
        if (w[1]) hold_m = w;
        if (w[0]) act_m = hold_m;
        note_dev();
        apb(1'b0, `DSCP_REG_RX, 32'h0, 1'b1, {15'h0, prev}, rd);
    endtask

    // Quick load or strobe: holding word goes active
    task automatic cmd_only(input logic [31:0] c);
        logic [31:0] rd;
        apb(1'b1, `DSCP_REG_CMD, c, 1'b0, 33'h0, rd);
        wait_idle();
        act_m = hold_m;
        note_dev();
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [17:0] w;
        logic [31:0] rd;
        int          i;
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_n = 1'b1;
        rd_chk = 1'b0;
        dev_chk = 1'b0;
        sh_m = 18'h0;
        hold_m = 18'h0;
        act_m = 18'h0;
        seed = 32'h3a1d_57fb;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Let the link sit idle after reset
        repeat (4) @(posedge pclk);
        note_dev();
        apb(1'b0, 8'h10, 32'h0, 1'b1, {1'b1, 32'h0}, rd);
        // Random words through all four flag codes
        for (i = 0; i < 14; i++) begin
            seed = lfsr_next(seed);
            w = seed[17:0];
            w[1:0] = (i < 12) ? i[1:0] : 2'b10;
            pin_n <= seed[20];
            send(w);
            if (i == 12) cmd_only(32'h2);
            if (i == 13) cmd_only(32'h4);
        end
        tally_and_finish();
    end
endmodule

`default_nettype wire
